// ==== hw/bsr_pkg.sv ====
/*
  Constants, field layouts and carriers for the status readback bank.
  Assumes a single fabric clock; build identity values are fixed here.
*/
package bsr_pkg;
  localparam int CHANNELS = 4;
  localparam int NUM_XCVR = 2 * CHANNELS;
  localparam int XIW = 3;
  // Host command field values
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h3;
  // Status word addresses
  localparam logic [3:0] ADDR_CFG_LINK = 4'h0;
  localparam logic [3:0] ADDR_RX_WORDS = 4'h1;
  localparam logic [3:0] ADDR_BIT_ERRS = 4'h2;
  localparam logic [3:0] ADDR_IDENT = 4'h3;
  localparam logic [3:0] ADDR_DATE = 4'h4;
  localparam logic [3:0] ADDR_PORT_LOC = 4'h5;
  localparam logic [3:0] ADDR_SELECT = 4'h0;
  // Selection fields inside the control vector of address 0
  localparam int CTRL_CHAN_LSB = 0;
  localparam int CTRL_XCVR_BIT = 4;
  // Bit positions in status word 0
  localparam int POS_ENABLE = 11;
  localparam int POS_CHAN_LSB = 12;
  localparam int POS_ALIGNED = 25;
  localparam int POS_LINK = 26;
  localparam int POS_TX_LOCK = 27;
  localparam int POS_RX_LOCK = 28;
  localparam int POS_TX_CLK = 29;
  localparam int POS_RX_CLK_B = 30;
  localparam int POS_RX_CLK_A = 31;
  // Build constants
  localparam logic [7:0] WORD_WIDTH = 8'h14;
  localparam logic [3:0] CHANNEL_TOTAL = 4'h4;
  // Arbitrary neutral device type code
  localparam logic [7:0] DEVICE_TYPE = 8'h2A;
  localparam logic [7:0] VERSION_MAJOR = 8'h01;
  localparam logic [7:0] VERSION_MINOR = 8'h00;
  localparam logic [7:0] CALIBRATION_VERSION = 8'h01;
  localparam logic [7:0] BUILD_MONTH = 8'h01;
  localparam logic [7:0] BUILD_DAY = 8'h01;
  localparam logic [15:0] BUILD_YEAR = 16'h07D0;
  // Placement per transceiver, index {channel, second}
  localparam logic [NUM_XCVR*8-1:0] XCVR_LOC = 64'h0807060504030201;
  localparam logic [31:0] CNT_MAX = 32'hFFFFFFFF;

  typedef struct packed {
    logic [1:0] op;
    logic [3:0] addr;
    logic [25:0] ctrl;
  } bsr_host_cmd_t;

  typedef struct packed {
    logic aligned;
    logic link_up;
    logic tx_attach_lock;
    logic rx_attach_lock;
    logic rx_word_valid;
    logic [5:0] err_bits;
    logic [15:0] cfg_rdata;
  } bsr_xcvr_t;
endpackage

// ==== hw/bsr_status_bank.sv ====
/*
  Status readback bank: six read-only words over a parallel host port,
  plus received-word and bit-error counters per transceiver.
  Assumes host command inputs are synchronous to mclk and held for at
  least two cycles; transceiver flags are already in the mclk domain.
*/
// Behaviour
// - word 0 [7:0] gives data width, built as 20.
// - word 0 bit 11 mirrors the host interface enable level.
// - debug control interface enabled only while host interface disabled.
// - word 0 [15:12] gives number of channels built.
// - word 0 bit 25 set when selected transceiver is aligned.
// - word 0 bit 26 set when selected link is up.
// - word 0 bit 27 shows transmit attachment lock.
// - word 0 bit 28 shows receive attachment lock.
// - word 0 bit 29 shows transmit user clock stable.
// - bits 30 and 31 show receive clocks, second and first transceiver.
// - word 1 counts received words on selected transceiver.
// - counters restart at zero after system or counter reset.
// - both 32-bit counters wrap modulo 2^32 past maximum; word count wraps to zero.
// - word 2 counts bit errors on selected transceiver.
// - word 3 [7:0] gives target device type code.
// - word 3 gives version digits and calibration version.
// - word 4 gives build month, day and year.
// - word 5 [15:0] gives config port read data.
// - word 5 gives placement of second then first transceiver.
// - read code plus address; word appears two cycles later, holds.
// - selection follows latest host write to control address 0 made while host interface enabled.
`timescale 1ns/1ps
`default_nettype none
module bsr_status_bank (
  input wire logic mclk,
  input wire logic reset,
  input wire bsr_pkg::bsr_host_cmd_t host_cmd,
  input wire logic host_if_enable,
  input wire logic debug_if_request,
  input wire logic counter_clear,
  input wire bsr_pkg::bsr_xcvr_t xcvr_in [bsr_pkg::NUM_XCVR],
  input wire logic [bsr_pkg::CHANNELS-1:0] tx_user_clock_ok,
  input wire logic [bsr_pkg::NUM_XCVR-1:0] rx_user_clock_ok,
  output logic [31:0] status_out_r,
  output logic debug_enable_r
);
  import bsr_pkg::*;

  bsr_host_cmd_t cmd_r;
  logic [3:0] channel_select_r;
  logic transceiver_select_r;
  logic [31:0] rx_cnt_r [NUM_XCVR];
  logic [31:0] err_cnt_r [NUM_XCVR];
  logic [31:0] status_nxt;

  function automatic logic [31:0] bump(input logic [31:0] cur,
                                       input logic [31:0] inc);
    // Plain 32-bit sum: overflow drops the carry, so it wraps
    bump = cur + inc;
  endfunction

  function automatic logic is_cmd(input bsr_host_cmd_t c,
                                  input logic [1:0] op,
                                  input logic [3:0] addr);
    is_cmd = (c.op == op) && (c.addr == addr);
  endfunction

  // Selection decode
  wire sel_ok = channel_select_r < CHANNEL_TOTAL;
  wire [XIW-1:0] sel_idx = sel_ok ?
    {channel_select_r[XIW-2:0], transceiver_select_r} : '0;
  wire [XIW-2:0] sel_chan = sel_idx[XIW-1:1];
  wire [XIW-1:0] sel_first = {sel_chan, 1'b0};
  wire [XIW-1:0] sel_second = {sel_chan, 1'b1};
  wire bsr_xcvr_t sel_x = xcvr_in[sel_idx];

  // Commands are only honoured while the host interface is enabled
  wire cmd_live = host_if_enable;
  wire is_read = cmd_live && (cmd_r.op == OP_READ);
  wire sel_write = cmd_live && is_cmd(cmd_r, OP_WRITE, ADDR_SELECT);

  // Status word assembly
  wire [31:0] word_cfg_link = {
    sel_ok & rx_user_clock_ok[sel_first],
    sel_ok & rx_user_clock_ok[sel_second],
    sel_ok & tx_user_clock_ok[sel_chan],
    sel_ok & sel_x.rx_attach_lock,
    sel_ok & sel_x.tx_attach_lock,
    sel_ok & sel_x.link_up,
    sel_ok & sel_x.aligned,
    9'h000,
    CHANNEL_TOTAL,
    host_if_enable,
    3'h0,
    WORD_WIDTH
  };
  wire [31:0] word_rx = sel_ok ? rx_cnt_r[sel_idx] : 32'h0;
  wire [31:0] word_err = sel_ok ? err_cnt_r[sel_idx] : 32'h0;
  wire [31:0] word_ident = {CALIBRATION_VERSION, VERSION_MINOR,
                            VERSION_MAJOR, DEVICE_TYPE};
  wire [31:0] word_date = {BUILD_YEAR, BUILD_DAY, BUILD_MONTH};
  wire [31:0] word_port = {
    XCVR_LOC[sel_first*8 +: 8],
    XCVR_LOC[sel_second*8 +: 8],
    sel_ok ? sel_x.cfg_rdata : 16'h0000
  };

  // Unmapped addresses answer zero
  always_comb begin
    unique case (cmd_r.addr)
      ADDR_CFG_LINK: status_nxt = word_cfg_link;
      ADDR_RX_WORDS: status_nxt = word_rx;
      ADDR_BIT_ERRS: status_nxt = word_err;
      ADDR_IDENT: status_nxt = word_ident;
      ADDR_DATE: status_nxt = word_date;
      ADDR_PORT_LOC: status_nxt = word_port;
      default: status_nxt = 32'h0;
    endcase
  end

  // Stage one: sample the host bus
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmd_r <= '0;
    end else begin
      cmd_r <= host_cmd;
    end
  end

  // Stage two: output word, held between reads
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      status_out_r <= 32'h0;
    end else if (is_read) begin
      status_out_r <= status_nxt;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      channel_select_r <= 4'h0;
      transceiver_select_r <= 1'b0;
    end else if (sel_write) begin
      channel_select_r <= cmd_r.ctrl[CTRL_CHAN_LSB +: 4];
      transceiver_select_r <= cmd_r.ctrl[CTRL_XCVR_BIT];
    end
  end

  // Keeps the two control paths from fighting over the channel
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      debug_enable_r <= 1'b0;
    end else begin
      debug_enable_r <= debug_if_request & ~host_if_enable;
    end
  end

  // Counters clear while counter_clear holds, count from its release
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_XCVR; i++) begin
        rx_cnt_r[i] <= 32'h0;
        err_cnt_r[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < NUM_XCVR; i++) begin
        if (counter_clear) begin
          rx_cnt_r[i] <= 32'h0;
          err_cnt_r[i] <= 32'h0;
        end else if (xcvr_in[i].rx_word_valid) begin
          rx_cnt_r[i] <= bump(rx_cnt_r[i], 32'h1);
          err_cnt_r[i] <= bump(err_cnt_r[i],
                               {26'h0, xcvr_in[i].err_bits});
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  wire rd_cfg = is_read && (cmd_r.addr == ADDR_CFG_LINK);
  wire rd_err = is_read && (cmd_r.addr == ADDR_BIT_ERRS);
  wire rd_id = is_read && (cmd_r.addr == ADDR_IDENT);
  wire sel_wrap = sel_ok && !counter_clear &&
    xcvr_in[sel_idx].rx_word_valid && (rx_cnt_r[sel_idx] == CNT_MAX);
  wire rd_rx = is_read && (cmd_r.addr == ADDR_RX_WORDS);
  wire rd_date = is_read && (cmd_r.addr == ADDR_DATE);
  wire rd_port = is_read && (cmd_r.addr == ADDR_PORT_LOC);
  // Reads above the last status word
  wire rd_hole = is_read && (cmd_r.addr > ADDR_PORT_LOC);
  // Selected unit takes a word at this edge
  wire sel_count = sel_ok && !counter_clear && sel_x.rx_word_valid;

  AST_WIDTH: assert property (rd_cfg |=>
    status_out_r[7:0] == WORD_WIDTH)
    else $error("data width field wrong");

  AST_ENABLE: assert property (rd_cfg |=>
    status_out_r[POS_ENABLE] == $past(host_if_enable))
    else $error("enable bit does not follow host enable");

  AST_DEBUG: assert property (debug_enable_r |->
    !$past(host_if_enable))
    else $error("debug enabled while host interface enabled");

  AST_CHANNELS: assert property (rd_cfg |=>
    status_out_r[15:12] == CHANNEL_TOTAL)
    else $error("channel count field wrong");

  AST_LINK: assert property (rd_cfg && sel_ok |=>
    status_out_r[POS_LINK] == $past(sel_x.link_up))
    else $error("link bit does not follow selected link");

  AST_CLEAR: assert property (counter_clear |=>
    rx_cnt_r[0] == 32'h0 && err_cnt_r[0] == 32'h0)
    else $error("counter not cleared");

  AST_WRAP: assert property (sel_wrap |=>
    rx_cnt_r[$past(sel_idx)] == 32'h0)
    else $error("word counter did not wrap");

  AST_ERRWORD: assert property (rd_err && sel_ok |=>
    status_out_r == $past(err_cnt_r[sel_idx]))
    else $error("error count word wrong");

  AST_IDENT: assert property (rd_id |=>
    status_out_r[31:8] == {CALIBRATION_VERSION, VERSION_MINOR,
                           VERSION_MAJOR})
    else $error("version fields wrong");

  AST_HOLD: assert property (!is_read |=>
    $stable(status_out_r))
    else $error("output changed without a read");

  AST_SELECT: assert property (sel_write |=>
    channel_select_r == $past(cmd_r.ctrl[3:0]))
    else $error("channel select not taken");

  AST_RESERVED: assert property (rd_cfg |=>
    status_out_r[24:16] == 9'h000 && status_out_r[10:8] == 3'h0)
    else $error("reserved bits not zero");

  // Word 0 flags follow the unit selected when the read is acted on
  AST_ALIGNED: assert property (rd_cfg |=>
    status_out_r[POS_ALIGNED] == $past(sel_ok && sel_x.aligned))
    else $error("aligned bit does not follow selection");

  AST_TX_LOCK: assert property (rd_cfg |=>
    status_out_r[POS_TX_LOCK] == $past(sel_ok && sel_x.tx_attach_lock))
    else $error("transmit lock bit wrong");

  AST_RX_LOCK: assert property (rd_cfg |=>
    status_out_r[POS_RX_LOCK] == $past(sel_ok && sel_x.rx_attach_lock))
    else $error("receive lock bit wrong");

  AST_TX_CLK: assert property (rd_cfg |=>
    status_out_r[POS_TX_CLK] == $past(sel_ok && tx_user_clock_ok[sel_chan]))
    else $error("transmit clock bit wrong");

  AST_RX_CLK: assert property (rd_cfg |=>
    status_out_r[POS_RX_CLK_A] ==
      $past(sel_ok && rx_user_clock_ok[sel_first]) &&
    status_out_r[POS_RX_CLK_B] ==
      $past(sel_ok && rx_user_clock_ok[sel_second]))
    else $error("receive clock bits wrong");

  AST_RXWORD: assert property (rd_rx |=>
    status_out_r == $past(sel_ok ? rx_cnt_r[sel_idx] : 32'h0))
    else $error("word count word wrong");

  // Counting is modulo 2^32, so the carry out is dropped on purpose
  AST_COUNT: assert property (sel_count |=>
    rx_cnt_r[$past(sel_idx)] == 32'($past(rx_cnt_r[sel_idx]) + 32'h1))
    else $error("word counter did not step by one");

  AST_ERR_SUM: assert property (sel_count |=>
    err_cnt_r[$past(sel_idx)] ==
      32'($past(err_cnt_r[sel_idx]) + {26'h0, $past(sel_x.err_bits)}))
    else $error("error counter did not add the word errors");

  // Outside a counter clear, the selected unit's word counter must never move in a cycle without a received word
  AST_KEEP: assert property (sel_ok && !counter_clear &&
    !sel_x.rx_word_valid |=>
    rx_cnt_r[$past(sel_idx)] == $past(rx_cnt_r[sel_idx]))
    else $error("word counter moved without a word");

  AST_CLEAR_LAST: assert property (counter_clear |=>
    rx_cnt_r[NUM_XCVR-1] == 32'h0 && err_cnt_r[NUM_XCVR-1] == 32'h0)
    else $error("last counter not cleared");

  AST_DEVICE: assert property (rd_id |=>
    status_out_r[7:0] == DEVICE_TYPE)
    else $error("device type field wrong");

  AST_DATE: assert property (rd_date |=>
    status_out_r == {BUILD_YEAR, BUILD_DAY, BUILD_MONTH})
    else $error("build date word wrong");

  AST_CFGDATA: assert property (rd_port |=>
    status_out_r[15:0] == $past(sel_ok ? sel_x.cfg_rdata : 16'h0000))
    else $error("config port data field wrong");

  AST_LOCATION: assert property (rd_port |=>
    status_out_r[31:24] == $past(XCVR_LOC[sel_first*8 +: 8]) &&
    status_out_r[23:16] == $past(XCVR_LOC[sel_second*8 +: 8]))
    else $error("placement fields wrong");

  // Out-of-range channel: config port data in word 5 reads zero
  AST_UNSEL: assert property (rd_port && !sel_ok |=>
    status_out_r[15:0] == 16'h0000)
    else $error("config data not zero for absent channel");

  AST_HOLE: assert property (rd_hole |=>
    status_out_r == 32'h0)
    else $error("unmapped address not zero");

  AST_SEL_HOLD: assert property (!sel_write |=>
    $stable(channel_select_r) && $stable(transceiver_select_r))
    else $error("selection changed without a write");

  AST_SEL_XCVR: assert property (sel_write |=>
    transceiver_select_r == $past(cmd_r.ctrl[CTRL_XCVR_BIT]))
    else $error("transceiver select not taken");

  AST_DEBUG_ON: assert property (
    debug_if_request && !host_if_enable |=> debug_enable_r)
    else $error("debug path not granted while host interface off");

  AST_REFRESH: assert property (is_read |=>
    status_out_r == $past(status_nxt))
    else $error("read did not load the addressed word");

  // Host interface off: no read may reach the output
  AST_IGNORED: assert property (!host_if_enable |=>
    $stable(status_out_r))
    else $error("output changed while host interface off");

  COV_READ_CFG: cover property (rd_cfg ##1 rd_cfg);
  COV_SELECT: cover property (sel_write ##2 rd_err);
  COV_WRAP: cover property (sel_wrap);
  COV_COUNT: cover property (sel_count ##1 sel_count);
  COV_DEBUG: cover property (debug_enable_r ##1 !debug_enable_r);
endmodule
`default_nettype wire

// ==== sim/bsr_host_model.sv ====
/*
  Host model: puts one command on the parallel host port and holds it for three cycles.
  Assumes the bench pulses go for one cycle while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
module bsr_host_model (
  input wire logic mclk,
  input wire logic go,
  input wire bsr_pkg::bsr_host_cmd_t cmd,
  output var bsr_pkg::bsr_host_cmd_t host_cmd,
  output var logic busy
);
  import bsr_pkg::*;
  int cnt = 0;
  initial begin
    host_cmd = '0;
    busy = 1'b0;
  end
  always @(posedge mclk) begin
    if (go && !busy) begin
      host_cmd <= cmd;
      busy <= 1'b1;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      // Held three cycles, then idle op with scrambled rest
      if (cnt == 2) host_cmd <= {2'h0, ~host_cmd[29:0]};
      if (cnt == 4) busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== sim/bsr_status_bank_test.sv ====
/*
  Self-checking bench for the status readback bank.
  Assumes bsr_pkg and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module bsr_status_bank_test;
  import bsr_pkg::*;
  logic mclk = 0, reset = 1, go = 0, en = 1, dbg_req = 0, clr = 0;
  logic busy, dbg_en;
  bsr_host_cmd_t cmd = '0;
  bsr_host_cmd_t host_cmd;
  bsr_xcvr_t xi [NUM_XCVR];
  logic [CHANNELS-1:0] txc = '0;
  logic [NUM_XCVR-1:0] rxc = '0;
  logic [31:0] st;
  logic [31:0] w0_exp;
  int err_count = 0, cmp_count = 0;

  bsr_status_bank dut_u (.mclk(mclk), .reset(reset), .host_cmd(host_cmd),
    .host_if_enable(en), .debug_if_request(dbg_req), .counter_clear(clr),
    .xcvr_in(xi), .tx_user_clock_ok(txc), .rx_user_clock_ok(rxc),
    .status_out_r(st), .debug_enable_r(dbg_en));
  bsr_host_model host_u (.mclk(mclk), .go(go), .cmd(cmd),
    .host_cmd(host_cmd), .busy(busy));

  // Selected unit always shows the same pattern, all others the inverse of its aligned, link and lock flags
  assign w0_exp = {7'h5B, 9'h0, CHANNEL_TOTAL, 1'b1, 3'h0, WORD_WIDTH};

  initial forever #50 mclk = ~mclk;

  task automatic report_and_stop;
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: %h vs %h", $time, msg, seen, exp);
    end
  endtask

  task automatic op(input logic [1:0] code, input logic [3:0] a,
                    input logic [25:0] c);
    @(posedge mclk);
    go <= 1'b1;
    cmd <= {code, a, c};
    @(posedge mclk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 10 && busy; i++) begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp,
                    input string msg);
    op(OP_READ, a, 26'h0);
    chk(st, exp, msg);
  endtask

  task automatic sel_check(input int c, s);
    int idx;
    idx = 2 * c + s;
    op(OP_WRITE, ADDR_SELECT, 26'(s * 16 + c));
    @(posedge mclk);
    for (int k = 0; k < NUM_XCVR; k++) begin
      xi[k] <= {k == idx, k == idx, k != idx, k == idx, 1'b0, 6'h0,
                16'(16'hA500 + k)};
      rxc[k] <= (k / 2 != c) || (k == 2 * c);
    end
    for (int j = 0; j < CHANNELS; j++) txc[j] <= (j == c);
    rd(ADDR_CFG_LINK, w0_exp, "word 0");
    rd(ADDR_PORT_LOC, {XCVR_LOC[16*c+:8], XCVR_LOC[8*idx+8*(1-s)+:8],
       16'(16'hA500 + idx)}, "word 5");
  endtask

  task automatic count_check(input int idx);
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      xi[idx].rx_word_valid <= 1'b1;
      xi[idx].err_bits <= 6'h5;
      xi[idx ^ 1].rx_word_valid <= (i == 0);
    end
    @(posedge mclk);
    xi[idx].rx_word_valid <= 1'b0;
    xi[idx ^ 1].rx_word_valid <= 1'b0;
    rd(ADDR_RX_WORDS, 32'h3, "word count");
    rd(ADDR_BIT_ERRS, 32'hF, "error count");
    rd(ADDR_RX_WORDS, 32'h3, "count after reads");
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    rd(ADDR_RX_WORDS, 32'h0, "cleared words");
    rd(ADDR_BIT_ERRS, 32'h0, "cleared errors");
  endtask

  task automatic disabled_check;
    @(posedge mclk);
    en <= 1'b0;
    dbg_req <= 1'b1;
    op(OP_WRITE, ADDR_SELECT, 26'h0);
    op(OP_READ, ADDR_IDENT, 26'h0);
    chk({31'h0, dbg_en}, 32'h1, "debug path on");
    chk(st, 32'h0, "read while disabled");
    @(posedge mclk);
    en <= 1'b1;
    rd(ADDR_CFG_LINK, w0_exp, "selection kept");
    chk({31'h0, dbg_en}, 32'h0, "debug path off");
  endtask

  initial begin
    for (int k = 0; k < NUM_XCVR; k++) xi[k] = '0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk(st, 32'h0, "reset value");
    sel_check(0, 0);
    sel_check(2, 1);
    count_check(5);
    rd(ADDR_IDENT, {CALIBRATION_VERSION, VERSION_MINOR, VERSION_MAJOR,
       DEVICE_TYPE}, "word 3");
    rd(ADDR_DATE, {BUILD_YEAR, BUILD_DAY, BUILD_MONTH}, "word 4");
    rd(4'h6, 32'h0, "unmapped");
    disabled_check;
    op(OP_WRITE, ADDR_SELECT, 26'h5);
    rd(ADDR_PORT_LOC, {XCVR_LOC[7:0], XCVR_LOC[15:8], 16'h0000},
       "absent channel");
    report_and_stop;
  end

  // Whole run is about 150 cycles, well inside the 2000-cycle limit
  initial begin
    #200000;
    err_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
